// File: verilog/port_alt_function_led_mux.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
module port_alt_function_led_mux
  import pin_mux_pkg::*;
#(
  parameter int PKG_PINS = PKG_28_PIN
)(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [7:0]  pa_in_i,
  input  wire logic [7:0]  pb_in_i,
  input  wire logic [7:0]  pc_in_i,
  output logic      [7:0]  pa_out_o,
  output logic      [7:0]  pa_oe_o,
  output logic      [7:0]  pb_out_o,
  output logic      [7:0]  pb_oe_o,
  output logic      [7:0]  pc_out_o,
  output logic      [7:0]  pc_oe_o,
  input  wire logic        timer0_out_i,
  input  wire logic        timer0_out_n_i,
  input  wire logic        timer0_drives_i,
  input  wire logic        timer1_out_i,
  input  wire logic        timer1_out_n_i,
  input  wire logic        timer1_drives_i,
  input  wire logic        uart_drv_en_i,
  input  wire logic        uart_txd_i,
  input  wire logic        comparator_output_i,
  output logic             timer0_in_o,
  output logic             timer1_in_o,
  output logic             uart_cts_o,
  output logic             uart_rxd_o,
  output logic             external_clock_input_o,
  output logic      [7:0]  analog_en_o,
  output logic             vref_en_o,
  output logic             comparator_positive_input_o,
  output logic             comparator_negative_input_o,
  output logic      [7:0]  led_sink_en_o,
  output logic      [15:0] led_level_o,
  output logic             ext_reset_req_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_bits(input logic [7:0] sel,
                                           input logic [7:0] alt,
                                           input logic [7:0] gpio);
    pick_bits = (sel & alt) | (~sel & gpio);
  endfunction : pick_bits

  localparam bit SMALL_PKG = (PKG_PINS == PKG_8_PIN);
  localparam bit VREF_ON_B = (PKG_PINS == PKG_28_PIN);
  localparam bit VREF_ON_C = (PKG_PINS == PKG_20_PIN);
  localparam logic [7:0] PA_AF_RESET = SMALL_PKG ? PA_AF_RST_8P : AF_RST;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire pa_addr_wr = wr_i && (addr_i == PA_ADDR_OFF);
  wire pa_ctl_wr  = wr_i && (addr_i == PA_CTL_OFF);
  wire pb_addr_wr = wr_i && (addr_i == PB_ADDR_OFF);
  wire pb_ctl_wr  = wr_i && (addr_i == PB_CTL_OFF);
  wire pc_addr_wr = wr_i && (addr_i == PC_ADDR_OFF);
  wire pc_ctl_wr  = wr_i && (addr_i == PC_CTL_OFF);
  wire led_en_wr  = wr_i && (addr_i == LED_EN_OFF);
  wire led_h_wr   = wr_i && (addr_i == LED_LVL_H_OFF);
  wire led_l_wr   = wr_i && (addr_i == LED_LVL_L_OFF);

  logic [7:0] pa_sub, pa_dir, pa_af, pa_ctl_rd;
  logic [7:0] pb_sub, pb_dir, pb_af, pb_set_one, pb_ctl_rd;
  logic [7:0] pc_sub, pc_dir, pc_af, pc_set_one, pc_ctl_rd;
  logic [7:0] led_en, led_h, led_l;
  logic [7:0] pa_out_reg, pb_out_reg, pc_out_reg;
  logic [7:0] rdata_reg;

  // ----------------------------------------------------------------
  // port configuration banks
  // ----------------------------------------------------------------
  // port A carries no set registers, they read as zero
  port_cfg_bank #(.HAS_SET(1'b0), .AF_RESET(PA_AF_RESET)) u_port_a (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .addr_wr_i   (pa_addr_wr),
    .ctl_wr_i    (pa_ctl_wr),
    .wdata_i     (wdata_i),
    .sub_addr_o  (pa_sub),
    .dir_o       (pa_dir),
    .af_o        (pa_af),
    .set_one_o   (),
    .set_two_o   (),
    .ctl_rdata_o (pa_ctl_rd)
  );

  port_cfg_bank #(.HAS_SET(1'b1), .AF_RESET(AF_RST)) u_port_b (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .addr_wr_i   (pb_addr_wr),
    .ctl_wr_i    (pb_ctl_wr),
    .wdata_i     (wdata_i),
    .sub_addr_o  (pb_sub),
    .dir_o       (pb_dir),
    .af_o        (pb_af),
    .set_one_o   (pb_set_one),
    .set_two_o   (),
    .ctl_rdata_o (pb_ctl_rd)
  );

  port_cfg_bank #(.HAS_SET(1'b1), .AF_RESET(AF_RST)) u_port_c (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .addr_wr_i   (pc_addr_wr),
    .ctl_wr_i    (pc_ctl_wr),
    .wdata_i     (wdata_i),
    .sub_addr_o  (pc_sub),
    .dir_o       (pc_dir),
    .af_o        (pc_af),
    .set_one_o   (pc_set_one),
    .set_two_o   (),
    .ctl_rdata_o (pc_ctl_rd)
  );

  // ----------------------------------------------------------------
  // function selection
  // ----------------------------------------------------------------
  // set two never appears below: it only stores a value
  wire [7:0] pb_alt_one  = pb_af & pb_set_one;
  wire [7:0] pc_alt_one  = pc_af & pc_set_one;
  wire       pa2_is_rst  = SMALL_PKG && pa_af[RESET_PIN_BIT];

  wire [7:0] pa_alt_out = {timer1_out_i, timer1_out_n_i, uart_txd_i, 1'b0, 1'b0,
                           uart_drv_en_i, timer0_out_i, timer0_out_n_i};
  wire [7:0] pa_alt_oe  = {1'b1, timer1_drives_i, 1'b1, 1'b0, 1'b0,
                           ~pa2_is_rst, 1'b1, timer0_drives_i};
  wire [7:0] pc_alt_out = {4'h0, comparator_output_i, 3'h0};
  wire [7:0] pc_alt_oe  = {4'h0, pc_af[3] & ~pc_set_one[3], 3'h0};

  // a cleared enable falls back to data direction and output data
  wire [7:0] pa_out_next = pick_bits(pa_af, pa_alt_out, pa_out_reg);
  wire [7:0] pa_oe_next  = pick_bits(pa_af, pa_alt_oe, ~pa_dir);
  wire [7:0] pb_out_next = pick_bits(pb_af, 8'h00, pb_out_reg);
  wire [7:0] pb_oe_next  = pick_bits(pb_af, 8'h00, ~pb_dir);
  wire [7:0] pc_out_next = pick_bits(pc_af, pc_alt_out, pc_out_reg);
  wire [7:0] pc_oe_next  = pick_bits(pc_af, pc_alt_oe, ~pc_dir);

  wire [7:0] analog_next = {pb_alt_one[4], pc_alt_one[2:0], pb_alt_one[3:0]};
  wire       vref_next   = (VREF_ON_B && pb_alt_one[5])
                        || (VREF_ON_C && pc_alt_one[2]);
  wire       external_clock_input_next  = pb_af[3] & ~pb_set_one[3] & pb_in_i[3];
  wire       t0_in_next  = pa_af[0] & ~timer0_drives_i & pa_in_i[0];
  wire       t1_in_next  = pa_af[6] & ~timer1_drives_i & pa_in_i[6];
  // the pin is sampled only while the reset function owns it
  wire       rst_req_next = pa2_is_rst & ~pa_in_i[RESET_PIN_BIT];

  // ----------------------------------------------------------------
  // LED sink drivers
  // ----------------------------------------------------------------
  led_sink_ctrl u_led (
    .mclk_i              (mclk_i),
    .rst_b_i             (rst_b_i),
    .en_wr_i             (led_en_wr),
    .lvl_h_wr_i          (led_h_wr),
    .lvl_l_wr_i          (led_l_wr),
    .wdata_i             (wdata_i),
    .led_mode_i          (pc_alt_one),
    .led_driver_enable_o (led_en),
    .led_level_high_o    (led_h),
    .led_level_low_o     (led_l),
    .sink_en_o           (led_sink_en_o),
    .level_o             (led_level_o)
  );

  // ----------------------------------------------------------------
  // read data and output data registers
  // ----------------------------------------------------------------
  wire [7:0] rd_word = (addr_i == PA_ADDR_OFF)   ? pa_sub     :
                       (addr_i == PA_CTL_OFF)    ? pa_ctl_rd  :
                       (addr_i == PA_IN_OFF)     ? pa_in_i    :
                       (addr_i == PA_OUT_OFF)    ? pa_out_reg :
                       (addr_i == PB_ADDR_OFF)   ? pb_sub     :
                       (addr_i == PB_CTL_OFF)    ? pb_ctl_rd  :
                       (addr_i == PB_IN_OFF)     ? pb_in_i    :
                       (addr_i == PB_OUT_OFF)    ? pb_out_reg :
                       (addr_i == PC_ADDR_OFF)   ? pc_sub     :
                       (addr_i == PC_CTL_OFF)    ? pc_ctl_rd  :
                       (addr_i == PC_IN_OFF)     ? pc_in_i    :
                       (addr_i == PC_OUT_OFF)    ? pc_out_reg :
                       (addr_i == LED_EN_OFF)    ? led_en     :
                       (addr_i == LED_LVL_H_OFF) ? led_h      :
                       (addr_i == LED_LVL_L_OFF) ? led_l      : 8'h00;

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_i ? rd_word : 8'h00;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pa_out_reg <= OUT_RST;
      pb_out_reg <= OUT_RST;
      pc_out_reg <= OUT_RST;
    end
    else
    begin
      if (wr_i && addr_i == PA_OUT_OFF)
        pa_out_reg <= wdata_i;
      if (wr_i && addr_i == PB_OUT_OFF)
        pb_out_reg <= wdata_i;
      if (wr_i && addr_i == PC_OUT_OFF)
        pc_out_reg <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // pin and peripheral outputs
  // ----------------------------------------------------------------
  // one flop stage so every output is glitch free
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pa_out_o <= 8'h00;
      pa_oe_o  <= 8'h00;
      pb_out_o <= 8'h00;
      pb_oe_o  <= 8'h00;
      pc_out_o <= 8'h00;
      pc_oe_o  <= 8'h00;
    end
    else
    begin
      pa_out_o <= pa_out_next;
      pa_oe_o  <= pa_oe_next;
      pb_out_o <= pb_out_next;
      pb_oe_o  <= pb_oe_next;
      pc_out_o <= pc_out_next;
      pc_oe_o  <= pc_oe_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      timer0_in_o                 <= 1'b0;
      timer1_in_o                 <= 1'b0;
      uart_cts_o                  <= 1'b0;
      uart_rxd_o                  <= 1'b0;
      external_clock_input_o      <= 1'b0;
      analog_en_o                 <= 8'h00;
      vref_en_o                   <= 1'b0;
      comparator_positive_input_o <= 1'b0;
      comparator_negative_input_o <= 1'b0;
      ext_reset_req_o             <= 1'b0;
    end
    else
    begin
      timer0_in_o                 <= t0_in_next;
      timer1_in_o                 <= t1_in_next;
      uart_cts_o                  <= pa_af[3] & pa_in_i[3];
      uart_rxd_o                  <= pa_af[4] & pa_in_i[4];
      external_clock_input_o      <= external_clock_input_next;
      analog_en_o                 <= analog_next;
      vref_en_o                   <= vref_next;
      comparator_positive_input_o <= pc_alt_one[0];
      comparator_negative_input_o <= pc_alt_one[1];
      ext_reset_req_o             <= rst_req_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pa_enable;
    @(posedge mclk_i) disable iff (!rst_b_i)
    pa_af[1] |=> pa_oe_o[1] && (pa_out_o[1] == $past(timer0_out_i));
  endproperty
  a_pa_enable: assert property (p_pa_enable) else $error("pa1 not timer out");

  property p_timer_dir;
    @(posedge mclk_i) disable iff (!rst_b_i)
    pa_af[0] |=> (pa_oe_o[0] == $past(timer0_drives_i))
             && (timer0_in_o == ($past(pa_in_i[0]) && !$past(timer0_drives_i)));
  endproperty
  a_timer_dir: assert property (p_timer_dir) else $error("pa0 timer dir wrong");

  property p_pb_analog;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (pb_af[0] && pb_set_one[0]) ##1 (pb_af[0] && pb_set_one[0]) |-> ##1 analog_en_o[0];
  endproperty
  a_pb_analog: assert property (p_pb_analog) else $error("pb0 analog missing");

  property p_pb_clock;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (pb_af[3] && !pb_set_one[3])
      |=> (external_clock_input_o == $past(pb_in_i[3])) && !analog_en_o[3];
  endproperty
  a_pb_clock: assert property (p_pb_clock) else $error("pb3 clock route wrong");

  property p_vref_pkg;
    @(posedge mclk_i) disable iff (!rst_b_i)
    vref_en_o |-> $past((PKG_PINS == PKG_28_PIN && pb_af[5] && pb_set_one[5])
                     || (PKG_PINS == PKG_20_PIN && pc_af[2] && pc_set_one[2]));
  endproperty
  a_vref_pkg: assert property (p_vref_pkg) else $error("vref on wrong package");

  property p_led_gate;
    @(posedge mclk_i) disable iff (!rst_b_i)
    ##1 ((led_sink_en_o & ~($past(pc_af) & $past(pc_set_one) & $past(led_en))) == 8'h00);
  endproperty
  a_led_gate: assert property (p_led_gate) else $error("led sink without enables");

  property p_led_level;
    @(posedge mclk_i) disable iff (!rst_b_i)
    ##1 (led_level_o[15:14] == {$past(led_h[7]), $past(led_l[7])});
  endproperty
  a_led_level: assert property (p_led_level) else $error("led level mismatch");

  property p_reset_pin;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (SMALL_PKG && pa_af[RESET_PIN_BIT] && !pa_in_i[RESET_PIN_BIT]) |=> ext_reset_req_o;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin low ignored");

  property p_reset_restore;
    @(posedge mclk_i)
    $rose(rst_b_i) |-> (pa_af == PA_AF_RESET);
  endproperty
  a_reset_restore: assert property (p_reset_restore) else $error("pa af not restored");

  property p_sub_write;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (pc_ctl_wr && pc_sub == SUB_SET_ONE) |=> (pc_set_one == $past(wdata_i));
  endproperty
  a_sub_write: assert property (p_sub_write) else $error("set one write lost");

  property p_plain_gpio;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (pc_af == 8'h00) |=> (pc_oe_o == ~$past(pc_dir)) && (pc_out_o == $past(pc_out_reg));
  endproperty
  a_plain_gpio: assert property (p_plain_gpio) else $error("gpio fallback broken");

endmodule : port_alt_function_led_mux

// File: verilog/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // register bus map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  PA_ADDR_OFF   = 8'h00;
  localparam logic [7:0]  PA_CTL_OFF    = 8'h01;
  localparam logic [7:0]  PA_IN_OFF     = 8'h02;
  localparam logic [7:0]  PA_OUT_OFF    = 8'h03;
  localparam logic [7:0]  PB_ADDR_OFF   = 8'h04;
  localparam logic [7:0]  PB_CTL_OFF    = 8'h05;
  localparam logic [7:0]  PB_IN_OFF     = 8'h06;
  localparam logic [7:0]  PB_OUT_OFF    = 8'h07;
  localparam logic [7:0]  PC_ADDR_OFF   = 8'h08;
  localparam logic [7:0]  PC_CTL_OFF    = 8'h09;
  localparam logic [7:0]  PC_IN_OFF     = 8'h0a;
  localparam logic [7:0]  PC_OUT_OFF    = 8'h0b;
  localparam logic [7:0]  LED_EN_OFF    = 8'h0c;
  localparam logic [7:0]  LED_LVL_H_OFF = 8'h0d;
  localparam logic [7:0]  LED_LVL_L_OFF = 8'h0e;

  // ----------------------------------------------------------------
  // subregister index held in a port address register
  // ----------------------------------------------------------------
  localparam logic [7:0]  SUB_DIR       = 8'h01;
  localparam logic [7:0]  SUB_AF        = 8'h02;
  localparam logic [7:0]  SUB_SET_ONE   = 8'h07;
  localparam logic [7:0]  SUB_SET_TWO   = 8'h08;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_RST      = 8'h00;
  localparam logic [7:0]  DIR_RST       = 8'hff;
  localparam logic [7:0]  AF_RST        = 8'h00;
  localparam logic [7:0]  PA_AF_RST_8P  = 8'h04;
  localparam logic [7:0]  SET_RST       = 8'h00;
  localparam logic [7:0]  OUT_RST       = 8'h00;
  localparam logic [7:0]  LED_RST       = 8'h00;
  localparam int          RESET_PIN_BIT = 2;
  localparam int          PKG_8_PIN     = 8;
  localparam int          PKG_20_PIN    = 20;
  localparam int          PKG_28_PIN    = 28;

  // sink current code, {high bit, low bit} per pin
  typedef enum logic [1:0] {SINK_3MA, SINK_7MA, SINK_13MA, SINK_20MA} led_level_e;

endpackage : pin_mux_pkg

// File: verilog/port_cfg_bank.sv
`timescale 1ns/10ps
module port_cfg_bank
  import pin_mux_pkg::*;
#(
  parameter bit         HAS_SET  = 1'b1,
  parameter logic [7:0] AF_RESET = AF_RST
)(
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       addr_wr_i,
  input  wire logic       ctl_wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] sub_addr_o,
  output logic      [7:0] dir_o,
  output logic      [7:0] af_o,
  output logic      [7:0] set_one_o,
  output logic      [7:0] set_two_o,
  output logic      [7:0] ctl_rdata_o
);

  logic [7:0] addr_reg;
  logic [7:0] dir_reg;
  logic [7:0] af_reg;
  logic [7:0] set_one_reg;
  logic [7:0] set_two_reg;

  // set two is kept only for readback, it steers nothing
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_reg    <= ADDR_RST;
      dir_reg     <= DIR_RST;
      af_reg      <= AF_RESET;
      set_one_reg <= SET_RST;
      set_two_reg <= SET_RST;
    end
    else
    begin
      if (addr_wr_i)
        addr_reg <= wdata_i;
      if (ctl_wr_i && addr_reg == SUB_DIR)
        dir_reg <= wdata_i;
      if (ctl_wr_i && addr_reg == SUB_AF)
        af_reg <= wdata_i;
      if (ctl_wr_i && addr_reg == SUB_SET_ONE)
        set_one_reg <= wdata_i;
      if (ctl_wr_i && addr_reg == SUB_SET_TWO)
        set_two_reg <= wdata_i;
    end
  end

  assign sub_addr_o  = addr_reg;
  assign dir_o       = dir_reg;
  assign af_o        = af_reg;
  assign set_one_o   = HAS_SET ? set_one_reg : 8'h00;
  assign set_two_o   = HAS_SET ? set_two_reg : 8'h00;
  assign ctl_rdata_o = (addr_reg == SUB_DIR)     ? dir_reg   :
                       (addr_reg == SUB_AF)      ? af_reg    :
                       (addr_reg == SUB_SET_ONE) ? set_one_o :
                       (addr_reg == SUB_SET_TWO) ? set_two_o : 8'h00;

endmodule : port_cfg_bank

// File: verilog/led_sink_ctrl.sv
`timescale 1ns/10ps
module led_sink_ctrl
  import pin_mux_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        en_wr_i,
  input  wire logic        lvl_h_wr_i,
  input  wire logic        lvl_l_wr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  led_mode_i,
  output logic      [7:0]  led_driver_enable_o,
  output logic      [7:0]  led_level_high_o,
  output logic      [7:0]  led_level_low_o,
  output logic      [7:0]  sink_en_o,
  output logic      [15:0] level_o
);

  logic [7:0]  led_driver_enable_reg;
  logic [7:0]  led_level_high_reg;
  logic [7:0]  led_level_low_reg;
  logic [7:0]  sink_en_reg;
  logic [15:0] level_reg;
  logic [15:0] level_next;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      led_driver_enable_reg <= LED_RST;
      led_level_high_reg    <= LED_RST;
      led_level_low_reg     <= LED_RST;
    end
    else
    begin
      if (en_wr_i)
        led_driver_enable_reg <= wdata_i;
      if (lvl_h_wr_i)
        led_level_high_reg <= wdata_i;
      if (lvl_l_wr_i)
        led_level_low_reg <= wdata_i;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      level_next[2*i +: 2] = {led_level_high_reg[i], led_level_low_reg[i]};
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sink_en_reg <= 8'h00;
      level_reg   <= 16'h0000;
    end
    else
    begin
      sink_en_reg <= led_mode_i & led_driver_enable_reg;
      level_reg   <= level_next;
    end
  end

  assign led_driver_enable_o = led_driver_enable_reg;
  assign led_level_high_o    = led_level_high_reg;
  assign led_level_low_o     = led_level_low_reg;
  assign sink_en_o           = sink_en_reg;
  assign level_o             = level_reg;

endmodule : led_sink_ctrl

// File: verif/pin_far_side.sv
`timescale 1ns/10ps
module pin_far_side
(
  input  wire logic       rst_b_i,
  input  wire logic [7:0] pa_out_i,
  input  wire logic [7:0] pa_oe_i,
  input  wire logic [7:0] pb_out_i,
  input  wire logic [7:0] pb_oe_i,
  input  wire logic [7:0] pc_out_i,
  input  wire logic [7:0] pc_oe_i,
  input  wire logic [7:0] pa_drv_i,
  input  wire logic [7:0] pb_drv_i,
  input  wire logic [7:0] pc_drv_i,
  output logic      [7:0] pa_in_o,
  output logic      [7:0] pb_in_o,
  output logic      [7:0] pc_in_o
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // driven pin reads back itself; shared reset pin never held low in reset
  assign pa_in_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & pa_drv_i) | {5'h00, ~rst_b_i, 2'h0};
  assign pb_in_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & pb_drv_i);
  assign pc_in_o = (pc_oe_i & pc_out_i) | (~pc_oe_i & pc_drv_i);
endmodule : pin_far_side

// File: verif/port_alt_function_led_mux_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module port_alt_function_led_mux_tb
  import pin_mux_pkg::*;
;
  logic        mclk_i, rst_b_i, wr_i, rd_i;
  logic [7:0]  addr_i, wdata_i, rdata_o, pa_in, pb_in, pc_in, pa_drv, pb_drv, pc_drv;
  logic [7:0]  pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, analog_en, sink_en, d, pa8_oe;
  logic [8:0]  per;
  logic [15:0] lvl;
  logic        t0_in, t1_in, cts, rxd, ext_clk, vref, vref8, cmp_p, cmp_n, rst_req, rst8;
  logic [7:0]  r [9];
  int          miscompares, num_checks, cyc;

  port_alt_function_led_mux port_alt_function_led_mux_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pa_in_i(pa_in), .pb_in_i(pb_in), .pc_in_i(pc_in), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
    .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pc_out_o(pc_out), .pc_oe_o(pc_oe),
    .timer0_out_i(per[0]), .timer0_out_n_i(per[1]), .timer0_drives_i(per[2]),
    .timer1_out_i(per[3]), .timer1_out_n_i(per[4]), .timer1_drives_i(per[5]),
    .uart_drv_en_i(per[6]), .uart_txd_i(per[7]), .comparator_output_i(per[8]),
    .timer0_in_o(t0_in), .timer1_in_o(t1_in), .uart_cts_o(cts), .uart_rxd_o(rxd),
    .external_clock_input_o(ext_clk), .analog_en_o(analog_en), .vref_en_o(vref),
    .comparator_positive_input_o(cmp_p), .comparator_negative_input_o(cmp_n),
    .led_sink_en_o(sink_en), .led_level_o(lvl), .ext_reset_req_o(rst_req));

  // smallest package: shared reset pin, no reference pin
  port_alt_function_led_mux #(.PKG_PINS(PKG_8_PIN)) port_alt_function_led_mux_i8 (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(), .pa_in_i(pa_in), .pb_in_i(pb_in), .pc_in_i(pc_in), .pa_out_o(),
    .pa_oe_o(pa8_oe), .pb_out_o(), .pb_oe_o(), .pc_out_o(), .pc_oe_o(),
    .timer0_out_i(per[0]), .timer0_out_n_i(per[1]), .timer0_drives_i(per[2]),
    .timer1_out_i(per[3]), .timer1_out_n_i(per[4]), .timer1_drives_i(per[5]),
    .uart_drv_en_i(per[6]), .uart_txd_i(per[7]), .comparator_output_i(per[8]),
    .timer0_in_o(), .timer1_in_o(), .uart_cts_o(), .uart_rxd_o(), .external_clock_input_o(),
    .analog_en_o(), .vref_en_o(vref8), .comparator_positive_input_o(),
    .comparator_negative_input_o(), .led_sink_en_o(), .led_level_o(), .ext_reset_req_o(rst8));

  pin_far_side pin_far_side_i (.rst_b_i(rst_b_i), .pa_out_i(pa_out), .pa_oe_i(pa_oe),
    .pb_out_i(pb_out), .pb_oe_i(pb_oe), .pc_out_i(pc_out), .pc_oe_i(pc_oe),
    .pa_drv_i(pa_drv), .pb_drv_i(pb_drv), .pc_drv_i(pc_drv),
    .pa_in_o(pa_in), .pb_in_o(pb_in), .pc_in_o(pc_in));

  // ----------------------------------------------------------------
  // bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge mclk_i);
  endtask : rd

  task automatic sub(input logic [7:0] base, input logic [7:0] idx, input logic [7:0] v);
    wr(base, idx);
    wr(base + 8'h01, v);
  endtask : sub

  // pin outputs lag their cause by one cycle; leave margin
  task automatic settle();
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_an(logic [7:0] ba, bs, ca, cs);
    return {ba[4] & bs[4], ca[2:0] & cs[2:0], ba[3:0] & bs[3:0]};
  endfunction : exp_an

  function automatic logic [15:0] exp_lvl(logic [7:0] h, l);
    logic [15:0] e;
    for (int k = 0; k < 8; k++) e[2*k +: 2] = {h[k], l[k]};
    return e;
  endfunction : exp_lvl

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // no test needs more than a few thousand cycles
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    rst_b_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
    pa_drv = 8'h00; pb_drv = 8'h00; pc_drv = 8'h00; per = 9'h000;
    miscompares = 0; num_checks = 0; cyc = 0;
    void'($urandom(58));
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    settle();
    `CHK(pa_oe | pb_oe | pc_oe, 8'h00)
    `CHK({rst_req, rst8, pa8_oe[2]}, 3'b010)
    @(posedge mclk_i);
    wr(PC_ADDR_OFF, SUB_DIR);
    rd(PC_CTL_OFF);
    `CHK(d, DIR_RST)
    sub(PA_ADDR_OFF, SUB_SET_ONE, 8'hff);
    rd(PA_CTL_OFF);
    `CHK(d, 8'h00)
    rd(8'h0f);
    `CHK(d, 8'h00)
    // ----------------------------------------------------------------
    // port A: enable bit alone, timer picks direction
    // ----------------------------------------------------------------
    sub(PA_ADDR_OFF, SUB_AF, 8'h5b);
    per <= 9'h031;
    pa_drv <= 8'h19;
    settle();
    `CHK(t0_in, 1'b1)
    `CHK({t1_in, rxd, cts, pa_out[1]}, 4'h7)
    `CHK(pa_oe[6], 1'b1)
    `CHK(pa_out[6], per[4])
    `CHK({rst8, pa8_oe[2]}, 2'b00)
    @(posedge mclk_i);
    sub(PA_ADDR_OFF, SUB_DIR, 8'hfb);
    settle();
    `CHK(pa8_oe[2], 1'b1)
    // a mid-run reset must hand the shared pin back to reset
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    settle();
    `CHK({rst8, pa8_oe[2], pa_oe}, 10'h200)
    @(posedge mclk_i);
    sub(PB_ADDR_OFF, SUB_DIR, 8'h00);
    // ----------------------------------------------------------------
    // ports B and C, LED driver: corners then random
    // ----------------------------------------------------------------
    for (int i = 0; i < 12; i++)
    begin
      foreach (r[k]) r[k] = 8'($urandom);
      if (i < 2)
      begin
        r[0] = {8{i[0]}}; r[1] = 8'hff; r[3] = {8{i[0]}}; r[4] = 8'hff; r[6] = 8'hff;
      end
      sub(PB_ADDR_OFF, SUB_SET_TWO, r[2]);
      sub(PB_ADDR_OFF, SUB_SET_ONE, r[1]);
      sub(PB_ADDR_OFF, SUB_AF, r[0]);
      sub(PC_ADDR_OFF, SUB_SET_TWO, r[5]);
      sub(PC_ADDR_OFF, SUB_SET_ONE, r[4]);
      sub(PC_ADDR_OFF, SUB_AF, r[3]);
      wr(LED_EN_OFF, r[6]);
      wr(LED_LVL_H_OFF, r[7]);
      wr(LED_LVL_L_OFF, r[8]);
      wr(PB_OUT_OFF, r[2]);
      pb_drv <= 8'($urandom);
      per[8] <= 1'($urandom);
      settle();
      `CHK(analog_en, exp_an(r[0], r[1], r[3], r[4]))
      `CHK(analog_en[6:4], r[3][2:0] & r[4][2:0])
      `CHK(ext_clk, r[0][3] & ~r[1][3] & pb_drv[3])
      `CHK(vref, r[0][5] & r[1][5])
      `CHK({vref8, vref}, {1'b0, r[0][5] & r[1][5]})
      `CHK({cmp_n, cmp_p}, r[3][1:0] & r[4][1:0])
      `CHK(pc_out[3] & pc_oe[3], r[3][3] & ~r[4][3] & per[8])
      `CHK(pc_oe[3], r[3][3] & ~r[4][3])
      `CHK({pb_oe, pb_out, pc_oe & ~8'h08}, {~r[0], r[2] & ~r[0], 8'h00})
      `CHK(sink_en, r[3] & r[4] & r[6])
      `CHK(sink_en & ~r[6], 8'h00)
      `CHK(lvl, exp_lvl(r[7], r[8]))
      `CHK(led_level_e'(lvl[1:0]), led_level_e'({r[7][0], r[8][0]}))
      @(posedge mclk_i);
    end
    complete_run();
  end
endmodule : port_alt_function_led_mux_tb
